// ---- rtl/s16tc_top.sv ----
// Sixteen-bit timer/counter with prescaler, edge arming and compare trigger reset
`timescale 1ns/100ps
`include "s16tc_params.svh"

module s16tc_top #(
  parameter int PSC_WIDTH = 3
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  otherReset,
  input  wire logic                  sleepMode,
  input  wire logic                  ctrlWrEn,
  input  wire logic [7:0]            wrData,
  input  wire logic                  lowWrEn,
  input  wire logic                  highWrEn,
  input  wire logic                  flagClr,
  input  wire s16tc_pkg::s16tc_cmp_s cmpOne,
  input  wire s16tc_pkg::s16tc_cmp_s cmpTwo,
  input  wire logic                  oscInputPin,
  input  wire logic                  extClockPin,
  output logic                       oscOutputPin,
  output logic                       oscOutputEn,
  output logic [15:0]                countValue,
  output s16tc_pkg::s16tc_ctrl_s     ctrlValue,
  output logic                       overflowFlag,
  output logic                       wakeReq,
  output logic                       timeBaseValid
);
  import s16tc_pkg::*;

  s16tc_ctrl_s            ctrl_q;
  s16tc_ctrl_s            ctrl_d;
  logic [1:0]             div_q;
  logic [1:0]             div_d;
  logic                   extPrev_q;
  logic                   extPrev_d;
  s16tc_arm_e             arm_q;
  s16tc_arm_e             arm_d;
  logic [PSC_WIDTH-1:0]   psc_q;
  logic [PSC_WIDTH-1:0]   psc_d;
  logic [15:0]            count_q;
  logic [15:0]            count_d;
  logic                   flag_q;
  logic                   flag_d;
  logic                   wake_q;
  logic                   wake_d;
  logic                   tb_q;
  logic                   tb_d;
  logic                   oscOut_q;
  logic                   oscOut_d;
  logic                   oscEn_q;
  logic                   oscEn_d;
  logic                   tick;
  logic                   extSel;
  logic                   extRise;
  logic                   extFall;
  logic                   counterMode;
  logic                   asyncMode;
  logic                   srcPulse;
  logic [PSC_WIDTH-1:0]   pscMask;
  logic                   pscTerminal;
  logic                   incEn;
  logic                   cntWrite;
  logic                   trigHit;
  logic                   trigApply;
  logic                   ovfEvt;

  // Control register and clock source decode
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrlWrEn) begin
      ctrl_d = s16tc_ctrl_s'(wrData & `S16TC_CTRL_MASK);
    end
  end

  assign counterMode = ctrl_q.clockSourceSelect;
  assign asyncMode   = counterMode && ctrl_q.syncDisableBit;

  always_comb begin
    div_d = div_q + 2'h1;
    if (sleepMode) begin
      div_d = div_q;
    end
  end

  // Core clock stops in sleep, so the instruction clock does too
  assign tick = (div_q == `S16TC_DIV_LAST) && !sleepMode;

  assign extSel  = ctrl_q.lowPowerOscEnable ? oscInputPin : extClockPin;
  assign extRise = extSel && !extPrev_q;
  assign extFall = !extSel && extPrev_q;
  assign extPrev_d = extSel;

  // Arming drops whenever the counter leaves enabled counter mode
  always_comb begin
    arm_d = arm_q;
    if (!ctrl_q.timerOn || !counterMode) begin
      arm_d = ARM_WAIT;
    end else if (extFall) begin
      arm_d = ARM_READY;
    end
  end

  assign srcPulse = counterMode ? (extRise && (arm_q == ARM_READY)) : tick;

  // Prescaler
  assign pscMask = PSC_WIDTH'((1 << ctrl_q.prescale) - 1);
  assign pscTerminal = ((psc_q & pscMask) == pscMask);
  assign cntWrite = lowWrEn || highWrEn;

  always_comb begin
    psc_d = psc_q;
    if (cntWrite || otherReset) begin
      psc_d = PSC_WIDTH'(`S16TC_PSC_ZERO);
    end else if (ctrl_q.timerOn && srcPulse) begin
      // In counter mode the prescaler keeps running in sleep, ahead of the sync stage
      psc_d = pscTerminal ? PSC_WIDTH'(`S16TC_PSC_ZERO) : psc_q + PSC_WIDTH'(1);
    end
  end

  // Sync stage is off in sleep; the timer-mode term ignores the sync bit
  assign incEn = ctrl_q.timerOn && srcPulse && pscTerminal && !cntWrite
                 && (!counterMode || ctrl_q.syncDisableBit || !sleepMode);

  assign trigHit = (cmpOne.trigger && (cmpOne.compareModeField == `S16TC_MODE_SPECIAL))
                || (cmpTwo.trigger && (cmpTwo.compareModeField == `S16TC_MODE_SPECIAL));
  // Async counting does not honour the trigger; it is ignored there
  assign trigApply = trigHit && !asyncMode && !cntWrite;
  assign ovfEvt = incEn && !trigApply && (count_q == `S16TC_COUNT_MAX);

  // Counter: write, then trigger, then increment
  always_comb begin
    count_d = count_q;
    if (cntWrite) begin
      if (lowWrEn) begin
        count_d[7:0] = wrData;
      end
      if (highWrEn) begin
        count_d[15:8] = wrData;
      end
    end else if (trigApply) begin
      count_d = `S16TC_COUNT_ZERO;
    end else if (incEn) begin
      count_d = count_q + 16'h0001;
    end
  end

  // Overflow flag: set beats clear
  always_comb begin
    flag_d = flag_q;
    if (flagClr) begin
      flag_d = 1'b0;
    end
    if (ovfEvt) begin
      flag_d = 1'b1;
    end
  end

  assign wake_d   = ovfEvt && sleepMode && asyncMode;
  assign tb_d     = !asyncMode;
  assign oscEn_d  = ctrl_q.lowPowerOscEnable;
  assign oscOut_d = ctrl_q.lowPowerOscEnable && !oscInputPin;

  // Control survives every reset except power-on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= s16tc_ctrl_s'(`S16TC_CTRL_RESET);
      div_q     <= 2'h0;
      extPrev_q <= 1'b0;
      arm_q     <= ARM_WAIT;
      psc_q     <= PSC_WIDTH'(`S16TC_PSC_ZERO);
      flag_q    <= 1'b0;
      wake_q    <= 1'b0;
      tb_q      <= 1'b1;
      oscEn_q   <= 1'b0;
      oscOut_q  <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      div_q     <= div_d;
      extPrev_q <= extPrev_d;
      arm_q     <= arm_d;
      psc_q     <= psc_d;
      flag_q    <= flag_d;
      wake_q    <= wake_d;
      tb_q      <= tb_d;
      oscEn_q   <= oscEn_d;
      oscOut_q  <= oscOut_d;
    end
  end

  // Count has no reset at all; its power-up value is unknown
  always_ff @(posedge clk_sys) begin
    count_q <= count_d;
  end

  // Single registered word, so neither byte is ever torn
  assign countValue    = count_q;
  assign ctrlValue     = ctrl_q;
  assign overflowFlag  = flag_q;
  assign wakeReq       = wake_q;
  assign timeBaseValid = tb_q;
  assign oscOutputPin  = oscOut_q;
  assign oscOutputEn   = oscEn_q;

  sequence quietCount;
    !cntWrite && !trigHit;
  endsequence

  sequence timerRunning;
    ctrl_q.timerOn && !counterMode && (ctrl_q.prescale == 2'h0) && !sleepMode && !ctrlWrEn;
  endsequence

  AST_TRIG_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (trigHit && !asyncMode && !cntWrite) |=> (count_q == `S16TC_COUNT_ZERO))
    else $error("trigger did not clear count");

  AST_TRIG_NOFLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(flag_q) |-> $past(ovfEvt))
    else $error("flag set without overflow");

  AST_WRITE_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lowWrEn && trigHit) |=> (count_q[7:0] == $past(wrData)))
    else $error("trigger beat write");

  AST_PSC_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cntWrite |=> (psc_q == `S16TC_PSC_ZERO))
    else $error("prescaler not cleared by write");

  AST_SLEEP_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sleepMode && counterMode && !ctrl_q.syncDisableBit) ##0 quietCount |=> $stable(count_q))
    else $error("count moved in synchronized sleep");

  AST_UNARMED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (counterMode && (arm_q == ARM_WAIT)) ##0 quietCount |=> $stable(count_q))
    else $error("count moved before falling edge");

  AST_TIMER_RATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (incEn && !counterMode) ##1 timerRunning[*3] |-> (!incEn ##0 $past(!incEn) ##0 $past(!incEn, 2)))
    else $error("timer incremented faster than one in four");

  AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ovfEvt |=> ((count_q == `S16TC_COUNT_ZERO) && flag_q))
    else $error("overflow did not wrap and flag");

  AST_CTRL_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (otherReset && !ctrlWrEn) |=> $stable(ctrl_q))
    else $error("control changed on other reset");

  AST_TIMEBASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> (timeBaseValid == !($past(ctrl_q.clockSourceSelect) && $past(ctrl_q.syncDisableBit))))
    else $error("time base flag wrong");

  AST_SYNC_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl_q.timerOn && !counterMode && tick && pscTerminal) ##0 quietCount
    |=> (count_q == $past(count_q) + 16'h0001))
    else $error("timer mode count did not advance");

  AST_PSC_SLEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sleepMode && counterMode && !ctrl_q.syncDisableBit && ctrl_q.timerOn && srcPulse && !pscTerminal
     && !cntWrite && !otherReset) |=> (psc_q != $past(psc_q)))
    else $error("prescaler stalled in synchronized sleep");

  AST_ASYNC_SLEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (asyncMode && sleepMode && incEn) |=> (count_q == $past(count_q) + 16'h0001))
    else $error("async count stalled in sleep");

  AST_WAKE_ASYNC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wakeReq |-> (overflowFlag && $past(asyncMode && sleepMode)))
    else $error("wake request outside async sleep");

  AST_ARM_ON_FALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl_q.timerOn && counterMode && extFall) |=> (arm_q == ARM_READY))
    else $error("falling edge did not arm counting");

  AST_OSC_ENABLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> (oscOutputEn == $past(ctrl_q.lowPowerOscEnable)))
    else $error("oscillator enable not followed");

  AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (flagClr && !ovfEvt) |=> !overflowFlag)
    else $error("flag clear did not take");

endmodule : s16tc_top

// ---- rtl/s16tc_params.svh ----
// Constants of the sixteen-bit timer/counter
`ifndef S16TC_PARAMS_SVH
`define S16TC_PARAMS_SVH
`define S16TC_CTRL_RESET   8'h00
`define S16TC_BIT_ON       0
`define S16TC_BIT_CLKSEL   1
`define S16TC_BIT_SYNCDIS  2
`define S16TC_BIT_OSCEN    3
`define S16TC_PSC_LSB      4
`define S16TC_PSC_MSB      5
`define S16TC_CTRL_MASK    8'h3F
`define S16TC_MODE_SPECIAL 4'hB
`define S16TC_FOSC_DIV     4
`define S16TC_DIV_LAST     2'h3
`define S16TC_COUNT_MAX    16'hFFFF
`define S16TC_COUNT_ZERO   16'h0000
`define S16TC_PSC_ZERO     3'h0
`define S16TC_OSC_MAX_KHZ  200
`endif

// ---- rtl/s16tc_pkg.sv ----
// Types of the sixteen-bit timer/counter
package s16tc_pkg;
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] prescale;
    logic       lowPowerOscEnable;
    logic       syncDisableBit;
    logic       clockSourceSelect;
    logic       timerOn;
  } s16tc_ctrl_s;

  typedef struct packed {
    logic [3:0] compareModeField;
    logic       trigger;
  } s16tc_cmp_s;

  typedef enum logic [0:0] {
    ARM_WAIT  = 1'b0,
    ARM_READY = 1'b1
  } s16tc_arm_e;
endpackage : s16tc_pkg

// ---- bench/s16tc_clk_src.sv ----
// External clock source model driving either counter pin
`timescale 1ns/100ps
module s16tc_clk_src (
  input  wire logic       clk_sys,
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  input  wire logic       useOsc,
  output logic            extClockPin,
  output logic            oscInputPin,
  output logic            busy
);
  logic [7:0] left = 8'h00;
  logic [2:0] ph   = 3'h0;
  logic       lvl;
  // Idles low between bursts, so a fresh mode sees a rise before any fall
  always_ff @(posedge clk_sys) begin
    if (start) begin
      left <= pulses;
      ph   <= 3'h0;
    end else if (left != 8'h00) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h5) left <= left - 8'h01;
    end
  end
  assign lvl         = (left != 8'h00) && (ph < 3'h3);
  assign extClockPin = !useOsc && lvl;
  assign oscInputPin = useOsc && lvl;
  assign busy        = left != 8'h00;
endmodule : s16tc_clk_src

// ---- bench/s16tc_top_tb.sv ----
// Self-checking testbench of the sixteen-bit timer/counter
`timescale 1ns/100ps
module s16tc_top_tb;
  import s16tc_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, otherReset = 1'b0, sleepMode = 1'b0;
  logic        ctrlWrEn = 1'b0, lowWrEn = 1'b0, highWrEn = 1'b0, flagClr = 1'b0;
  logic        start = 1'b0, useOsc = 1'b0, seenWake = 1'b0;
  logic [7:0]  wrData = 8'h00, pulses = 8'h00;
  s16tc_cmp_s  cmpOne = '0, cmpTwo = '0;
  logic        oscInputPin, extClockPin, busy, oscOutputPin, oscOutputEn;
  logic        overflowFlag, wakeReq, timeBaseValid;
  logic [15:0] countValue, a;
  s16tc_ctrl_s ctrlValue;
  int          num_errors = 0, compares = 0;

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (wakeReq === 1'b1) seenWake <= 1'b1;

  s16tc_top dut (.clk_sys, .rst_n, .otherReset, .sleepMode, .ctrlWrEn, .wrData, .lowWrEn, .highWrEn,
    .flagClr, .cmpOne, .cmpTwo, .oscInputPin, .extClockPin, .oscOutputPin, .oscOutputEn, .countValue,
    .ctrlValue, .overflowFlag, .wakeReq, .timeBaseValid);
  s16tc_clk_src src (.clk_sys, .start, .pulses, .useOsc, .extClockPin, .oscInputPin, .busy);

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic ctrlW(input logic [7:0] d);
    @(posedge clk_sys);
    ctrlWrEn <= 1'b1;
    wrData   <= d;
    @(posedge clk_sys);
    ctrlWrEn <= 1'b0;
  endtask : ctrlW
  // Bytes go one at a time since both share wrData
  task automatic cntW(input logic [7:0] h, input logic [7:0] l);
    @(posedge clk_sys);
    lowWrEn <= 1'b1;
    wrData  <= l;
    @(posedge clk_sys);
    lowWrEn  <= 1'b0;
    highWrEn <= 1'b1;
    wrData   <= h;
    @(posedge clk_sys);
    highWrEn <= 1'b0;
  endtask : cntW
  task automatic trig(input logic two, input logic [3:0] m, input logic wr);
    @(posedge clk_sys);
    if (two) cmpTwo <= {m, 1'b1};
    else cmpOne <= {m, 1'b1};
    lowWrEn  <= wr;
    highWrEn <= wr;
    wrData   <= 8'h5A;
    @(posedge clk_sys);
    cmpOne   <= '0;
    cmpTwo   <= '0;
    lowWrEn  <= 1'b0;
    highWrEn <= 1'b0;
    #1;
  endtask : trig
  // Passing through a stopped state drops the edge arming every time
  task automatic mode(input logic [7:0] c, input logic s);
    ctrlW(8'h00);
    ctrlW(c);
    @(posedge clk_sys);
    sleepMode <= s;
    tick(2);
    a = countValue;
  endtask : mode
  task automatic burst(input logic o, input logic [7:0] n);
    @(posedge clk_sys);
    useOsc <= o;
    pulses <= n;
    start  <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    tick(1);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) tick(1);
    if (busy !== 1'b0) begin
      num_errors++;
    end
    tick(3);
  endtask : burst
  task automatic measure(input logic [7:0] c, input int n, input logic [15:0] k);
    ctrlW(c);
    tick(2);
    a = countValue;
    tick(n);
    check(countValue - a, k);
  endtask : measure
  task automatic finish_test();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    check({8'h00, ctrlValue}, 16'h0000);
    check({15'h0, timeBaseValid}, 16'h0001);
    cntW(8'h00, 8'h00);
    measure(8'h01, 40, 16'h000A);
    measure(8'h05, 40, 16'h000A);
    for (int p = 0; p < 4; p++) measure(8'((p << 4) | 1), 16 << p, 16'h0004);
    mode(8'h03, 1'b0);
    burst(1'b0, 8'h05);
    check(countValue - a, 16'h0004);
    a = countValue;
    burst(1'b0, 8'h03);
    check(countValue - a, 16'h0003);
    mode(8'h0B, 1'b0);
    // Oscillator start-up wait is software's job
    tick(8);
    burst(1'b0, 8'h03);
    check(countValue - a, 16'h0000);
    burst(1'b1, 8'h05);
    check(countValue - a, 16'h0004);
    check({15'h0, oscOutputEn}, 16'h0001);
    check({15'h0, oscOutputPin}, 16'h0001);
    // Prescale field 1 (divide by two) so the prescaler visibly moves while the count holds
    mode(8'h13, 1'b1);
    burst(1'b0, 8'h05);
    check(countValue - a, 16'h0000);
    ctrlW(8'h00);
    cntW(8'hFF, 8'hFF);
    mode(8'h07, 1'b1);
    burst(1'b0, 8'h02);
    check(countValue, 16'h0000);
    check({15'h0, overflowFlag}, 16'h0001);
    check({15'h0, seenWake}, 16'h0001);
    check({15'h0, timeBaseValid}, 16'h0000);
    mode(8'h00, 1'b0);
    @(posedge clk_sys);
    flagClr <= 1'b1;
    @(posedge clk_sys);
    flagClr <= 1'b0;
    cntW(8'h12, 8'h34);
    trig(1'b0, 4'hB, 1'b0);
    check(countValue, 16'h0000);
    check({15'h0, overflowFlag}, 16'h0000);
    cntW(8'h12, 8'h34);
    trig(1'b1, 4'hA, 1'b0);
    check(countValue, 16'h1234);
    trig(1'b1, 4'hB, 1'b0);
    check(countValue, 16'h0000);
    trig(1'b0, 4'hB, 1'b1);
    check(countValue, 16'h5A5A);
    ctrlW(8'h06);
    trig(1'b0, 4'hB, 1'b0);
    check(countValue, 16'h5A5A);
    @(posedge clk_sys);
    otherReset <= 1'b1;
    @(posedge clk_sys);
    otherReset <= 1'b0;
    tick(1);
    check({8'h00, ctrlValue}, 16'h0006);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    check({8'h00, ctrlValue}, 16'h0000);
    check(countValue, 16'h5A5A);
    finish_test();
  end

  // Whole run is some 600 cycles
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule : s16tc_top_tb
